// *** hw/talm_pkg.sv ***
`default_nettype none
package talm_pkg;
    // register indices
    localparam logic [6:0] TALM_IDX_TEMP1      = 7'h27;
    localparam logic [6:0] TALM_IDX_OVER1      = 7'h39;
    localparam logic [6:0] TALM_IDX_HYST1      = 7'h3A;
    localparam logic [6:0] TALM_IDX_STAT_FIRST = 7'h41;
    localparam logic [6:0] TALM_IDX_STAT_SEC   = 7'h42;
    localparam logic [6:0] TALM_IDX_PROP_SEL   = 7'h4C;
    localparam logic [6:0] TALM_IDX_T23_UPPER  = 7'h50;
    localparam logic [6:0] TALM_IDX_T23_LSB    = 7'h51;
    localparam logic [6:0] TALM_IDX_T23_CFG    = 7'h52;
    localparam logic [6:0] TALM_IDX_HYST_UPPER = 7'h53;
    localparam logic [6:0] TALM_IDX_HYST_LSB   = 7'h54;
    localparam logic [6:0] TALM_IDX_OVER_UPPER = 7'h55;
    localparam logic [6:0] TALM_IDX_OVER_LSB   = 7'h56;
    // bank codes for 50h..56h
    localparam logic [2:0] TALM_BANK_S2 = 3'h1;
    localparam logic [2:0] TALM_BANK_S3 = 3'h2;
    // field positions
    localparam int TALM_BIT_S1_HIGH   = 4;
    localparam int TALM_BIT_S2_HIGH   = 5;
    localparam int TALM_BIT_S3_HIGH   = 5;
    localparam int TALM_BIT_T23_TWO   = 6;
    localparam int TALM_BIT_OVT_LATCH = 1;
    localparam int TALM_BIT_LSB_POS   = 7;
    // reset values and mode codes
    localparam logic [7:0] TALM_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] TALM_OVER1_RST   = 8'h50;
    localparam logic [7:0] TALM_HYST1_RST   = 8'h4B;
    localparam logic [8:0] TALM_OVER23_RST  = 9'h0A0;
    localparam logic [8:0] TALM_HYST23_RST  = 9'h096;
    localparam logic [7:0] TALM_COMP_HYST   = 8'h7F;
endpackage : talm_pkg
`default_nettype wire

// *** hw/talm_alarm.sv ***
`timescale 1ns/10ps
`default_nettype none
module talm_alarm
    import talm_pkg::*;
#(
    parameter int W = 9
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         conv_done,
    input  wire logic [W-1:0] temp,
    input  wire logic [W-1:0] over_lim,
    input  wire logic [W-1:0] hyst_lim,
    input  wire logic         exit_at_over,
    input  wire logic         two_times,
    input  wire logic         ovt_latched,
    input  wire logic         smi_pending,
    input  wire logic         ovt_clear,
    output logic              smi_event_r,
    output logic              ovt_r
);
    logic hot_r;
    logic hot_nxt;
    logic smi_event_nxt;
    logic ovt_nxt;
    logic above_over;
    logic below_exit;
    logic cross_up;
    logic cross_down;

    // ****************************************
    // limit compare and alarm state, per conversion
    // ****************************************
    always_comb begin
        above_over    = $signed(temp) > $signed(over_lim);
        below_exit    = exit_at_over ? !above_over
                                     : ($signed(temp) < $signed(hyst_lim));
        cross_up      = conv_done && !hot_r && above_over;
        cross_down    = conv_done && hot_r && below_exit;
        hot_nxt       = hot_r;
        if (cross_up) begin
            hot_nxt = 1'b1;
        end else if (cross_down) begin
            hot_nxt = 1'b0;
        end
        if (two_times) begin
            smi_event_nxt = cross_up || (cross_down && !smi_pending);
        end else begin
            smi_event_nxt = conv_done && hot_nxt && !smi_pending;
        end
        if (ovt_latched) begin
            ovt_nxt = (ovt_r && !ovt_clear) || cross_up || cross_down;
        end else begin
            ovt_nxt = hot_nxt;
        end
    end

    // registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hot_r       <= 1'b0;
            smi_event_r <= 1'b0;
            ovt_r       <= 1'b0;
        end else begin
            hot_r       <= hot_nxt;
            smi_event_r <= smi_event_nxt;
            ovt_r       <= ovt_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_TWO_UP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (two_times && conv_done && !hot_r && above_over) |=> smi_event_r)
        else $error("two-times upward crossing gave no event");
    AST_COMP_PENDING: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!two_times && smi_pending) |=> !smi_event_r)
        else $error("comparator event raised while pending");
    AST_OVT_COMP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!ovt_latched && !$past(ovt_latched)) |-> (ovt_r == hot_r))
        else $error("comparator over-temp output not following alarm state");
    AST_OVT_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ovt_latched && ovt_r && !ovt_clear) |=> ovt_r)
        else $error("latched over-temp output dropped without a read");
    AST_NO_EVT_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !conv_done |=> !smi_event_r)
        else $error("event outside a completed conversion");
    COV_TWO_DOWN: cover property (@(posedge ref_clk) disable iff (!reset_n)
        two_times && cross_down && !smi_pending);
    COV_OVT_LATCH: cover property (@(posedge ref_clk) disable iff (!reset_n)
        ovt_latched && cross_down);
endmodule : talm_alarm
`default_nettype wire

// *** hw/talm_top.sv ***
// Function
// - sensor one reads 8-bit two's complement, sensors two/three 9-bit half-degree steps
// - index 27h returns sensor one's full 8-bit result
// - sensors two/three: upper eight bits at 50h, lsb at 51h bit 7, per bank
// - sensor one hysteresis limit of 127 selects comparator interrupt mode
// - comparator: exceeding over limit interrupts; status read clears; no repeat while pending
// - sensor one comparator re-raises each conversion while above over limit
// - sensor one hysteresis below over limit selects two-times mode
// - two-times: interrupt above over limit, again below hysteresis after clear
// - sensors two/three interrupt mode comes from 4Ch bit 6
// - sensors two/three comparator re-raise each conversion until below hysteresis
// - over-temp mode for sensors two/three from 52h bit 1, both banks alike
// - over-temp comparator: asserted above over limit until below hysteresis
// - over-temp latched mode: held until temperature read, relatched below hysteresis
// - high events: sensor one bit 4, two bit 5 first status, three bit 5 second
`timescale 1ns/10ps
`default_nettype none
module talm_top
    import talm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       thermal_input_one_done,
    input  wire logic [7:0] thermal_input_one_data,
    input  wire logic       thermal_input_two_done,
    input  wire logic [8:0] thermal_input_two_data,
    input  wire logic       thermal_input_three_done,
    input  wire logic [8:0] thermal_input_three_data,
    input  wire logic [6:0] reg_index,
    input  wire logic [2:0] bank_sel,
    input  wire logic       reg_rd,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_r,
    output logic            mgmt_interrupt_out_n_r,
    output logic            over_temp_out_n_r
);
    logic [7:0] temp1_r,  temp1_nxt;
    logic [8:0] temp2_r,  temp2_nxt;
    logic [8:0] temp3_r,  temp3_nxt;
    logic [7:0] over1_r,  over1_nxt;
    logic [7:0] hyst1_r,  hyst1_nxt;
    logic [8:0] over2_r,  over2_nxt;
    logic [8:0] hyst2_r,  hyst2_nxt;
    logic [8:0] over3_r,  over3_nxt;
    logic [8:0] hyst3_r,  hyst3_nxt;
    logic       two23_r,  two23_nxt;
    logic       latch2_r, latch2_nxt;
    logic       latch3_r, latch3_nxt;
    logic [7:0] stat1_r,  stat1_nxt;
    logic [7:0] stat2_r,  stat2_nxt;
    logic [7:0] rdata_nxt;
    logic       ev1, ev2, ev3;
    logic       ovt2, ovt3;
    logic       s1_two, s1_exit;
    logic       rd_s2_temp, rd_s3_temp;
    logic       rd_stat1, rd_stat2;

    // true when the access hits idx within bank b
    function automatic logic hit(input logic [6:0] idx, input logic [2:0] b);
        return (reg_index == idx) && (bank_sel == b);
    endfunction

    // ****************************************
    // conversion results and limit registers
    // ****************************************
    always_comb begin
        temp1_nxt  = thermal_input_one_done   ? thermal_input_one_data   : temp1_r;
        temp2_nxt  = thermal_input_two_done   ? thermal_input_two_data   : temp2_r;
        temp3_nxt  = thermal_input_three_done ? thermal_input_three_data : temp3_r;
        over1_nxt  = over1_r;
        hyst1_nxt  = hyst1_r;
        over2_nxt  = over2_r;
        hyst2_nxt  = hyst2_r;
        over3_nxt  = over3_r;
        hyst3_nxt  = hyst3_r;
        two23_nxt  = two23_r;
        latch2_nxt = latch2_r;
        latch3_nxt = latch3_r;
        if (reg_wr) begin
            if (reg_index == TALM_IDX_OVER1) begin
                over1_nxt = reg_wdata;
            end else if (reg_index == TALM_IDX_HYST1) begin
                hyst1_nxt = reg_wdata;
            end else if (reg_index == TALM_IDX_PROP_SEL) begin
                two23_nxt = reg_wdata[TALM_BIT_T23_TWO];
            end else if (hit(TALM_IDX_T23_CFG, TALM_BANK_S2)) begin
                latch2_nxt = reg_wdata[TALM_BIT_OVT_LATCH];
            end else if (hit(TALM_IDX_T23_CFG, TALM_BANK_S3)) begin
                latch3_nxt = reg_wdata[TALM_BIT_OVT_LATCH];
            end else if (hit(TALM_IDX_HYST_UPPER, TALM_BANK_S2)) begin
                hyst2_nxt = {reg_wdata, hyst2_r[0]};
            end else if (hit(TALM_IDX_HYST_LSB, TALM_BANK_S2)) begin
                hyst2_nxt = {hyst2_r[8:1], reg_wdata[TALM_BIT_LSB_POS]};
            end else if (hit(TALM_IDX_OVER_UPPER, TALM_BANK_S2)) begin
                over2_nxt = {reg_wdata, over2_r[0]};
            end else if (hit(TALM_IDX_OVER_LSB, TALM_BANK_S2)) begin
                over2_nxt = {over2_r[8:1], reg_wdata[TALM_BIT_LSB_POS]};
            end else if (hit(TALM_IDX_HYST_UPPER, TALM_BANK_S3)) begin
                hyst3_nxt = {reg_wdata, hyst3_r[0]};
            end else if (hit(TALM_IDX_HYST_LSB, TALM_BANK_S3)) begin
                hyst3_nxt = {hyst3_r[8:1], reg_wdata[TALM_BIT_LSB_POS]};
            end else if (hit(TALM_IDX_OVER_UPPER, TALM_BANK_S3)) begin
                over3_nxt = {reg_wdata, over3_r[0]};
            end else if (hit(TALM_IDX_OVER_LSB, TALM_BANK_S3)) begin
                over3_nxt = {over3_r[8:1], reg_wdata[TALM_BIT_LSB_POS]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp1_r  <= TALM_BYTE_ZERO;
            temp2_r  <= 9'h000;
            temp3_r  <= 9'h000;
            over1_r  <= TALM_OVER1_RST;
            hyst1_r  <= TALM_HYST1_RST;
            over2_r  <= TALM_OVER23_RST;
            hyst2_r  <= TALM_HYST23_RST;
            over3_r  <= TALM_OVER23_RST;
            hyst3_r  <= TALM_HYST23_RST;
            two23_r  <= 1'b0;
            latch2_r <= 1'b0;
            latch3_r <= 1'b0;
        end else begin
            temp1_r  <= temp1_nxt;
            temp2_r  <= temp2_nxt;
            temp3_r  <= temp3_nxt;
            over1_r  <= over1_nxt;
            hyst1_r  <= hyst1_nxt;
            over2_r  <= over2_nxt;
            hyst2_r  <= hyst2_nxt;
            over3_r  <= over3_nxt;
            hyst3_r  <= hyst3_nxt;
            two23_r  <= two23_nxt;
            latch2_r <= latch2_nxt;
            latch3_r <= latch3_nxt;
        end
    end

    // ****************************************
    // mode selection and read-side effects
    // ****************************************
    always_comb begin
        s1_two     = (hyst1_r != TALM_COMP_HYST) && ($signed(hyst1_r) < $signed(over1_r));
        s1_exit    = !s1_two;                       // sensor one comparator leaves at over limit
        rd_stat1   = reg_rd && (reg_index == TALM_IDX_STAT_FIRST);
        rd_stat2   = reg_rd && (reg_index == TALM_IDX_STAT_SEC);
        rd_s2_temp = reg_rd && (hit(TALM_IDX_T23_UPPER, TALM_BANK_S2)
                                || hit(TALM_IDX_T23_LSB, TALM_BANK_S2));
        rd_s3_temp = reg_rd && (hit(TALM_IDX_T23_UPPER, TALM_BANK_S3)
                                || hit(TALM_IDX_T23_LSB, TALM_BANK_S3));
    end

    talm_alarm #(.W(8)) u_alarm1 (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .conv_done    (thermal_input_one_done),
        .temp         (thermal_input_one_data),
        .over_lim     (over1_r),
        .hyst_lim     (hyst1_r),
        .exit_at_over (s1_exit),
        .two_times    (s1_two),
        .ovt_latched  (1'b0),
        .smi_pending  (stat1_r[TALM_BIT_S1_HIGH]),
        .ovt_clear    (1'b0),
        .smi_event_r  (ev1),
        .ovt_r        ()
    );

    talm_alarm #(.W(9)) u_alarm2 (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .conv_done    (thermal_input_two_done),
        .temp         (thermal_input_two_data),
        .over_lim     (over2_r),
        .hyst_lim     (hyst2_r),
        .exit_at_over (1'b0),
        .two_times    (two23_r),
        .ovt_latched  (latch2_r),
        .smi_pending  (stat1_r[TALM_BIT_S2_HIGH]),
        .ovt_clear    (rd_s2_temp),
        .smi_event_r  (ev2),
        .ovt_r        (ovt2)
    );

    talm_alarm #(.W(9)) u_alarm3 (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .conv_done    (thermal_input_three_done),
        .temp         (thermal_input_three_data),
        .over_lim     (over3_r),
        .hyst_lim     (hyst3_r),
        .exit_at_over (1'b0),
        .two_times    (two23_r),
        .ovt_latched  (latch3_r),
        .smi_pending  (stat2_r[TALM_BIT_S3_HIGH]),
        .ovt_clear    (rd_s3_temp),
        .smi_event_r  (ev3),
        .ovt_r        (ovt3)
    );

    // ****************************************
    // status, read data and output pins
    // ****************************************
    always_comb begin
        stat1_nxt = rd_stat1 ? TALM_BYTE_ZERO : stat1_r;   // read clears, set below wins
        stat2_nxt = rd_stat2 ? TALM_BYTE_ZERO : stat2_r;
        stat1_nxt[TALM_BIT_S1_HIGH] = stat1_nxt[TALM_BIT_S1_HIGH] | ev1;
        stat1_nxt[TALM_BIT_S2_HIGH] = stat1_nxt[TALM_BIT_S2_HIGH] | ev2;
        stat2_nxt[TALM_BIT_S3_HIGH] = stat2_nxt[TALM_BIT_S3_HIGH] | ev3;
        rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            if (reg_index == TALM_IDX_TEMP1) begin
                rdata_nxt = temp1_r;
            end else if (reg_index == TALM_IDX_OVER1) begin
                rdata_nxt = over1_r;
            end else if (reg_index == TALM_IDX_HYST1) begin
                rdata_nxt = hyst1_r;
            end else if (reg_index == TALM_IDX_STAT_FIRST) begin
                rdata_nxt = stat1_r;
            end else if (reg_index == TALM_IDX_STAT_SEC) begin
                rdata_nxt = stat2_r;
            end else if (reg_index == TALM_IDX_PROP_SEL) begin
                rdata_nxt = TALM_BYTE_ZERO;
                rdata_nxt[TALM_BIT_T23_TWO] = two23_r;
            end else if (hit(TALM_IDX_T23_UPPER, TALM_BANK_S2)) begin
                rdata_nxt = temp2_r[8:1];
            end else if (hit(TALM_IDX_T23_LSB, TALM_BANK_S2)) begin
                rdata_nxt = {temp2_r[0], 7'h00};
            end else if (hit(TALM_IDX_T23_UPPER, TALM_BANK_S3)) begin
                rdata_nxt = temp3_r[8:1];
            end else if (hit(TALM_IDX_T23_LSB, TALM_BANK_S3)) begin
                rdata_nxt = {temp3_r[0], 7'h00};
            end else if (hit(TALM_IDX_T23_CFG, TALM_BANK_S2)) begin
                rdata_nxt = {6'h00, latch2_r, 1'b0};
            end else if (hit(TALM_IDX_T23_CFG, TALM_BANK_S3)) begin
                rdata_nxt = {6'h00, latch3_r, 1'b0};
            end else begin
                rdata_nxt = TALM_BYTE_ZERO;                              // unmapped reads zero
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat1_r                <= TALM_BYTE_ZERO;
            stat2_r                <= TALM_BYTE_ZERO;
            reg_rdata_r            <= TALM_BYTE_ZERO;
            mgmt_interrupt_out_n_r <= 1'b1;
            over_temp_out_n_r      <= 1'b1;
        end else begin
            stat1_r                <= stat1_nxt;
            stat2_r                <= stat2_nxt;
            reg_rdata_r            <= rdata_nxt;
            mgmt_interrupt_out_n_r <= ~(|stat1_nxt | |stat2_nxt);
            over_temp_out_n_r      <= ~(ovt2 | ovt3);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_STAT_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ev2 |=> stat1_r[TALM_BIT_S2_HIGH])
        else $error("sensor two event not recorded in status");
    AST_STAT_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (rd_stat2 && !ev3) |=> (stat2_r == TALM_BYTE_ZERO))
        else $error("second status not cleared by read");
    AST_SMI_PIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mgmt_interrupt_out_n_r == !(|stat1_r || |stat2_r))
        else $error("interrupt pin disagrees with status");
    AST_READ_T1: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_rd && reg_index == TALM_IDX_TEMP1) |=> (reg_rdata_r == $past(temp1_r)))
        else $error("sensor one reading wrong");
    AST_READ_LSB: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_rd && hit(TALM_IDX_T23_LSB, TALM_BANK_S3))
        |=> (reg_rdata_r[TALM_BIT_LSB_POS] == $past(temp3_r[0])))
        else $error("sensor three lsb misplaced");
    AST_MODE_COMP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (hyst1_r == TALM_COMP_HYST && thermal_input_one_done && !stat1_r[TALM_BIT_S1_HIGH]
         && ($signed(thermal_input_one_data) > $signed(over1_r))) |=> ev1)
        else $error("sensor one not in comparator mode");
    AST_OVT_PIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 (over_temp_out_n_r == !($past(ovt2) || $past(ovt3))))
        else $error("over-temp pin disagrees with alarm");
    COV_S1_EVENT: cover property (@(posedge ref_clk) disable iff (!reset_n) ev1 && s1_two);
    COV_S3_EVENT: cover property (@(posedge ref_clk) disable iff (!reset_n) ev3 && !two23_r);
    COV_CLEAR_SET: cover property (@(posedge ref_clk) disable iff (!reset_n) rd_stat1 && ev1);
endmodule : talm_top
`default_nettype wire

// *** test/talm_sensor_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module talm_sensor_model (
    input  wire logic       ref_clk,
    output logic            done_one,
    output logic      [7:0] data_one,
    output logic            done_two,
    output logic      [8:0] data_two,
    output logic            done_three,
    output logic      [8:0] data_three
);
    // quiet lines at time zero
    initial begin
        {done_one, done_two, done_three} = 3'h0;
        {data_one, data_two, data_three} = 26'h0000000;
    end

    // one result pulse; idle data lines show the inverse afterwards
    task automatic conv(input int sel, input logic [8:0] val);
        @(posedge ref_clk);
        case (sel)
            1: begin data_one <= val[7:0]; done_one <= 1'h1; end
            2: begin data_two <= val; done_two <= 1'h1; end
            default: begin data_three <= val; done_three <= 1'h1; end
        endcase
        @(posedge ref_clk);
        {done_one, done_two, done_three} <= 3'h0;
        data_one <= ~data_one;
        data_two <= ~data_two;
        data_three <= ~data_three;
    endtask
endmodule // talm_sensor_model
`default_nettype wire

// *** test/talm_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module talm_top_tb;
    import talm_pkg::*;
    logic       ref_clk = 1'h0;
    logic       reset_n = 1'h0;
    logic       reg_rd = 1'h0;
    logic       reg_wr = 1'h0;
    logic [6:0] reg_index = 7'h00;
    logic [2:0] bank_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_r;
    logic       mgmt_n, ovt_n, d1, d2, d3;
    logic [7:0] t1;
    logic [8:0] t2, t3;
    int         error_cnt = 0;
    int         checks_done = 0;

    always #25 ref_clk = ~ref_clk;

    talm_sensor_model sens (.ref_clk(ref_clk), .done_one(d1), .data_one(t1), .done_two(d2),
        .data_two(t2), .done_three(d3), .data_three(t3));

    talm_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .thermal_input_one_done(d1),
        .thermal_input_one_data(t1), .thermal_input_two_done(d2),
        .thermal_input_two_data(t2), .thermal_input_three_done(d3),
        .thermal_input_three_data(t3), .reg_index(reg_index), .bank_sel(bank_sel),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .mgmt_interrupt_out_n_r(mgmt_n), .over_temp_out_n_r(ovt_n));

    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // read strobe for one cycle, data settled after the next edge
    task automatic rc(input logic [6:0] idx, input logic [2:0] bk, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_index <= idx;
        bank_sel <= bk;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        chk(reg_rdata_r, exp);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [2:0] bk, input logic [7:0] d);
        @(posedge ref_clk);
        reg_index <= idx;
        bank_sel <= bk;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask

    // conversion, then let event and status flops land
    task automatic cv(input int sel, input logic [8:0] val);
        sens.conv(sel, val);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // ****************************************
    // watchdog and main sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        @(negedge ref_clk);
        chk({6'h00, mgmt_n, ovt_n}, 8'h03);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        rc(TALM_IDX_STAT_SEC, 3'h0, 8'h00);
        rc(7'h7E, 3'h0, 8'h00);
        cv(1, 9'h0E7);
        rc(TALM_IDX_TEMP1, 3'h0, 8'hE7);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        cv(2, 9'h1CF);
        rc(TALM_IDX_T23_UPPER, TALM_BANK_S2, 8'hE7);
        rc(TALM_IDX_T23_LSB, TALM_BANK_S2, 8'h80);
        cv(3, 9'h032);
        rc(TALM_IDX_T23_UPPER, TALM_BANK_S3, 8'h19);
        rc(TALM_IDX_T23_LSB, TALM_BANK_S3, 8'h00);
        // sensor one two-times by default limits
        cv(1, 9'h060);
        chk({7'h00, mgmt_n}, 8'h00);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        chk({7'h00, mgmt_n}, 8'h01);
        cv(1, 9'h058);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        cv(1, 9'h040);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        // sensor one comparator
        wr(TALM_IDX_HYST1, 3'h0, TALM_COMP_HYST);
        cv(1, 9'h060);
        cv(1, 9'h060);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        cv(1, 9'h060);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        cv(1, 9'h040);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        // sensor two comparator, over-temp comparator
        cv(2, 9'h0C8);
        chk({7'h00, ovt_n}, 8'h00);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h20);
        cv(2, 9'h0A0);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h20);
        chk({7'h00, ovt_n}, 8'h00);
        cv(2, 9'h080);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h00);
        chk({7'h00, ovt_n}, 8'h01);
        // sensor three two-times
        wr(TALM_IDX_PROP_SEL, 3'h0, 8'h40);
        cv(3, 9'h0C8);
        rc(TALM_IDX_STAT_SEC, 3'h0, 8'h20);
        cv(3, 9'h0A0);
        rc(TALM_IDX_STAT_SEC, 3'h0, 8'h00);
        cv(3, 9'h080);
        rc(TALM_IDX_STAT_SEC, 3'h0, 8'h20);
        // latched over-temp, same value in both banks
        wr(TALM_IDX_T23_CFG, TALM_BANK_S2, 8'h02);
        wr(TALM_IDX_T23_CFG, TALM_BANK_S3, 8'h02);
        cv(3, 9'h0C8);
        chk({7'h00, ovt_n}, 8'h00);
        rc(TALM_IDX_T23_UPPER, TALM_BANK_S3, 8'h64);
        @(negedge ref_clk);                             // clear reaches the pin one edge later
        chk({7'h00, ovt_n}, 8'h01);
        cv(3, 9'h0C8);
        chk({7'h00, ovt_n}, 8'h01);
        cv(3, 9'h080);
        chk({7'h00, ovt_n}, 8'h00);
        rc(TALM_IDX_T23_LSB, TALM_BANK_S3, 8'h00);
        @(negedge ref_clk);                             // clear reaches the pin one edge later
        chk({7'h00, ovt_n}, 8'h01);
        // sensor one hysteresis above over limit stays comparator
        wr(TALM_IDX_HYST1, 3'h0, 8'h60);
        cv(1, 9'h060);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        cv(1, 9'h060);
        rc(TALM_IDX_STAT_FIRST, 3'h0, 8'h10);
        end_sim();
    end
endmodule // talm_top_tb
`default_nettype wire
